// >>> osc_partner_model.sv
// Behavioural oscillator and PLL model on the far side of the sequencer.
`timescale 1ns/10ps
module osc_partner_model (
  input wire clk,
  input wire oscRun,
  input wire pllOn,
  output logic oscClockIn,
  output logic pllLockedIn
);
  logic [1:0] divCnt = 2'h0;
  initial oscClockIn = 1'b0;
  initial pllLockedIn = 1'b0;
  // A stopped oscillator stands low, so no start-up edges can leak in.
  // The divider restarts with the oscillator, so the first rising edge has a fixed phase.
  always @(posedge clk) begin
    if (!oscRun) begin
      divCnt <= 2'h0;
      oscClockIn <= 1'b0;
    end else begin
      divCnt <= divCnt + 2'h1;
      if (divCnt == 2'h3) oscClockIn <= ~oscClockIn;
    end
    pllLockedIn <= pllOn;
  end
endmodule // osc_partner_model

// >>> reset_release_sequencer.v
// Reset release sequencer: system reset hold, clock release and monitor start.
`timescale 1ns/10ps
`include "reset_release_sequencer_regs.vh"

module reset_release_sequencer #(
  parameter [23:0] POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_CYCLES,
  parameter [23:0] MONITOR_START_CYCLES = `MONITOR_START_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire powerOnEvent,
  input wire brownOutEvent,
  input wire masterClearEvent,
  input wire watchdogEvent,
  input wire softwareEvent,
  input wire illegalOpEvent,
  input wire uninitRegEvent,
  input wire trapConflictEvent,
  input wire wakeEvent,
  input wire regulatorEnable,
  input wire clockSwitchEnable,
  input wire monitorEnable,
  input wire [2:0] newOscSelectConfig,
  input wire oscClockIn,
  input wire pllLockedIn,
  output reg systemResetSignal,
  output reg clockReleased,
  output reg cpuRunEnable,
  output reg [23:0] programCounterLoad,
  output reg [2:0] currentOscSelect,
  output reg monitorActive,
  output reg oscFailTrap,
  output reg [2:0] resetCause
);

  // ==========================================================================
  // Sequencer states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_HOLD = 5'h02;
  localparam [4:0] ST_WAIT_CLK = 5'h04;
  localparam [4:0] ST_MON_DELAY = 5'h08;
  localparam [4:0] ST_RUN = 5'h10;

  // Fixed delays in clk cycles; the power-up timer and monitor delay stay parameters.
  localparam [23:0] POWER_ON_CYC = `POWER_ON_CYCLES;
  localparam [23:0] STARTUP_ON_CYC = `STARTUP_REG_ON_CYCLES;
  localparam [23:0] STATE_RST_CYC = `STATE_RESET_CYCLES;
  localparam [23:0] PLL_LOCK_CYC = `PLL_LOCK_CYCLES;
  localparam [9:0] OST_LAST = 10'h3ff;

  // Cause codes on resetCause; zero means no event has been seen since rst_n.
  localparam [2:0] CAUSE_NONE = 3'h0;
  localparam [2:0] CAUSE_POWER_ON = 3'h1;
  localparam [2:0] CAUSE_BROWN_OUT = 3'h2;
  localparam [2:0] CAUSE_OTHER = 3'h3;
  localparam [2:0] CAUSE_WAKE = 3'h4;

  // Pins from the oscillator and reset sources are asynchronous to clk.
  reg [1:0] porSync_reg, borSync_reg, mclrSync_reg, wdtSync_reg, swrSync_reg;
  reg [1:0] iopSync_reg, uwrSync_reg, trapSync_reg, wakeSync_reg;
  reg [1:0] oscSync_reg, lockSync_reg;
  reg oscPrev_reg;
  reg [4:0] state_reg;
  reg [23:0] holdCnt_reg;
  reg [23:0] lockCnt_reg;
  reg [9:0] ostCnt_reg;
  reg ostDone_reg, lockDone_reg, needOst_reg, needLock_reg;
  reg [23:0] monCnt_reg;
  reg [2:0] oscSel_next;

  // ==========================================================================
  // Event decode
  // Priority is power-on, brown-out, the other resets, then wake.
  wire porIn = porSync_reg[1];
  wire borIn = borSync_reg[1];
  wire otherIn = mclrSync_reg[1] | wdtSync_reg[1] | swrSync_reg[1] | iopSync_reg[1] |
    uwrSync_reg[1] | trapSync_reg[1];
  wire wakeIn = wakeSync_reg[1];
  wire anyReset = porIn | borIn | otherIn | wakeIn;
  wire oscEdge = oscSync_reg[1] & ~oscPrev_reg;
  wire lockIn = lockSync_reg[1];
  // The clock is valid once every delay that this source needs has run out.
  wire needClockWait = needOst_reg | needLock_reg;
  wire clockReady = (ostDone_reg | !needOst_reg) & (lockDone_reg | !needLock_reg);

  // ==========================================================================
  // Clock source helpers
  function isPll;
    input [2:0] sel;
    begin
      isPll = (sel == `OSC_FAST_RC_PLL) | (sel == `OSC_CRYSTAL_PLL) |
        (sel == `OSC_EXT_CLOCK_PLL);
    end
  endfunction

  function isCrystal;
    input [2:0] sel;
    begin
      isCrystal = (sel == `OSC_CRYSTAL) | (sel == `OSC_CRYSTAL_PLL) |
        (sel == `OSC_SECONDARY);
    end
  endfunction

  function [23:0] startupCycles;
    input regOn;
    begin
      startupCycles = regOn ? STARTUP_ON_CYC : POWER_UP_TIMER_CYCLES;
    end
  endfunction

  // One saturating decrement for every down-counter, so none can wrap to a long hold.
  function [23:0] countDown;
    input [23:0] value;
    begin
      countDown = (value == 24'h000000) ? 24'h000000 : value - 24'h000001;
    end
  endfunction

  // ==========================================================================
  // Synchronisers
  // Only the second stage of each pair feeds logic; the first may be metastable.
  always @(posedge clk) begin
    if (!rst_n) begin
      porSync_reg <= 2'h0;
      borSync_reg <= 2'h0;
      mclrSync_reg <= 2'h0;
      wdtSync_reg <= 2'h0;
      swrSync_reg <= 2'h0;
      iopSync_reg <= 2'h0;
      uwrSync_reg <= 2'h0;
      trapSync_reg <= 2'h0;
      wakeSync_reg <= 2'h0;
      oscSync_reg <= 2'h0;
      lockSync_reg <= 2'h0;
      oscPrev_reg <= 1'b0;
    end else begin
      porSync_reg <= {porSync_reg[0], powerOnEvent};
      borSync_reg <= {borSync_reg[0], brownOutEvent};
      mclrSync_reg <= {mclrSync_reg[0], masterClearEvent};
      wdtSync_reg <= {wdtSync_reg[0], watchdogEvent};
      swrSync_reg <= {swrSync_reg[0], softwareEvent};
      iopSync_reg <= {iopSync_reg[0], illegalOpEvent};
      uwrSync_reg <= {uwrSync_reg[0], uninitRegEvent};
      trapSync_reg <= {trapSync_reg[0], trapConflictEvent};
      wakeSync_reg <= {wakeSync_reg[0], wakeEvent};
      oscSync_reg <= {oscSync_reg[0], oscClockIn};
      lockSync_reg <= {lockSync_reg[0], pllLockedIn};
      oscPrev_reg <= oscSync_reg[1];
    end
  end

  // Power-on and brown-out, or any event while clockSwitchEnable is low, reload the configured source; others keep it.
  always @* begin
    oscSel_next = currentOscSelect;
    if (porIn | borIn | !clockSwitchEnable) begin
      oscSel_next = newOscSelectConfig;
    end
  end

  // ==========================================================================
  // Sequencer
  // A held event reloads the counters every cycle, so each hold is timed from its last cycle.
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      holdCnt_reg <= POWER_ON_CYC + STARTUP_ON_CYC + STATE_RST_CYC;
      lockCnt_reg <= 24'h000000;
      ostCnt_reg <= 10'h000;
      ostDone_reg <= 1'b0;
      lockDone_reg <= 1'b0;
      needOst_reg <= 1'b0;
      needLock_reg <= 1'b0;
      monCnt_reg <= 24'h000000;
      systemResetSignal <= 1'b1;
      clockReleased <= 1'b0;
      cpuRunEnable <= 1'b0;
      programCounterLoad <= `RESET_VECTOR;
      currentOscSelect <= `OSC_FAST_RC;
      monitorActive <= 1'b0;
      oscFailTrap <= 1'b0;
      resetCause <= CAUSE_NONE;
    end else if (anyReset) begin
      // Every event restarts the hold; outputs and PC return to reset values, but currentOscSelect and resetCause are reloaded.
      state_reg <= ST_HOLD;
      systemResetSignal <= 1'b1;
      clockReleased <= 1'b0;
      cpuRunEnable <= 1'b0;
      monitorActive <= 1'b0;
      oscFailTrap <= 1'b0;
      programCounterLoad <= `RESET_VECTOR;
      currentOscSelect <= oscSel_next;
      ostCnt_reg <= 10'h000;
      lockCnt_reg <= 24'h000000;
      ostDone_reg <= 1'b0;
      lockDone_reg <= 1'b0;
      needOst_reg <= 1'b0;
      needLock_reg <= 1'b0;
      monCnt_reg <= MONITOR_START_CYCLES;
      if (porIn) begin
        holdCnt_reg <= POWER_ON_CYC + startupCycles(regulatorEnable) + STATE_RST_CYC;
        resetCause <= CAUSE_POWER_ON;
        needOst_reg <= isCrystal(oscSel_next);
        needLock_reg <= isPll(oscSel_next);
      end else if (borIn) begin
        holdCnt_reg <= startupCycles(regulatorEnable) + STATE_RST_CYC;
        resetCause <= CAUSE_BROWN_OUT;
        needOst_reg <= isCrystal(oscSel_next);
        needLock_reg <= isPll(oscSel_next);
      end else if (otherIn) begin
        holdCnt_reg <= STATE_RST_CYC;
        resetCause <= CAUSE_OTHER;
      end else begin
        holdCnt_reg <= regulatorEnable ? STARTUP_ON_CYC : 24'h000001;
        resetCause <= CAUSE_WAKE;
      end
    end else begin
      // Oscillator start-up and PLL lock count beside the reset hold.
      if (needOst_reg && !ostDone_reg && oscEdge) begin
        ostCnt_reg <= ostCnt_reg + 10'h001;
        if (ostCnt_reg == OST_LAST) begin
          ostDone_reg <= 1'b1;
        end
      end
      // A drop of the lock indication pauses the count rather than restarting it.
      if (needLock_reg && !lockDone_reg && lockIn) begin
        lockCnt_reg <= lockCnt_reg + 24'h000001;
        if (lockCnt_reg >= PLL_LOCK_CYC - 24'h000001) begin
          lockDone_reg <= 1'b1;
        end
      end
      case (state_reg)
        ST_IDLE: begin
          // After rst_n nothing is released until some reset source fires.
          state_reg <= ST_IDLE;
        end
        ST_HOLD: begin
          if (holdCnt_reg <= 24'h000001) begin
            systemResetSignal <= 1'b0;
            state_reg <= ST_WAIT_CLK;
          end else begin
            holdCnt_reg <= countDown(holdCnt_reg);
          end
        end
        ST_WAIT_CLK: begin
          // System reset is already low here; fetch still waits for a valid clock.
          // The monitor delay runs meanwhile, so with monitorEnable set a missing clock still ends the wait.
          if (monCnt_reg != 24'h000000 && needClockWait) begin
            monCnt_reg <= countDown(monCnt_reg);
          end
          if (clockReady) begin
            clockReleased <= 1'b1;
            cpuRunEnable <= 1'b1;
            state_reg <= ST_MON_DELAY;
          end else if (monitorEnable && (monCnt_reg <= 24'h000001 ||
              !needClockWait)) begin
            currentOscSelect <= `OSC_FAST_RC;
            oscFailTrap <= 1'b1;
            monitorActive <= 1'b1;
            clockReleased <= 1'b1;
            cpuRunEnable <= 1'b1;
            state_reg <= ST_RUN;
          end
        end
        ST_MON_DELAY: begin
          if (!needClockWait || monCnt_reg <= 24'h000001) begin
            monitorActive <= monitorEnable;
            state_reg <= ST_RUN;
          end else begin
            monCnt_reg <= countDown(monCnt_reg);
          end
        end
        ST_RUN: begin
          // Running stays put; only a reset event leaves this state.
          state_reg <= ST_RUN;
        end
        default: begin
          // A corrupted state code parks in idle until the next reset event.
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // reset_release_sequencer

// >>> reset_release_sequencer_asserts.sv
// Port checker for the reset release sequencer.
`timescale 1ns/10ps
module reset_release_sequencer_asserts #(
  parameter [23:0] POWER_UP_TIMER_CYCLES = 24'd50,
  parameter [23:0] MONITOR_START_CYCLES = 24'd40
) (
  input wire clk,
  input wire rst_n,
  input wire powerOnEvent,
  input wire systemResetSignal,
  input wire clockReleased,
  input wire cpuRunEnable,
  input wire [23:0] programCounterLoad,
  input wire [2:0] currentOscSelect,
  input wire monitorActive,
  input wire oscFailTrap,
  input wire [2:0] resetCause
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Helper counters
  // Both saturate so a long hold never wraps into a false short one.
  logic [15:0] holdCnt;
  logic [23:0] relCnt;
  always @(posedge clk) begin
    if (!rst_n || !systemResetSignal) holdCnt <= 16'h0000;
    else if (holdCnt != 16'hffff) holdCnt <= holdCnt + 16'h0001;
    if (!rst_n || systemResetSignal) relCnt <= 24'h000000;
    else if (relCnt != 24'hffffff) relCnt <= relCnt + 24'h000001;
  end
  // ==========================================================================
  // Properties
  chk_pc_vector: assert property (programCounterLoad == 24'h000000)
    else $error("program counter load not zero");
  chk_fetch_clock: assert property (cpuRunEnable |-> clockReleased)
    else $error("fetch enabled without released clock");
  chk_fetch_reset: assert property (cpuRunEnable |-> !systemResetSignal)
    else $error("fetch enabled during system reset");
  chk_event_holds: assert property (powerOnEvent |-> ##[1:3] systemResetSignal)
    else $error("power-on event did not assert system reset");
  chk_fail_frc: assert property (oscFailTrap |-> currentOscSelect == 3'h0 && clockReleased)
    else $error("fail trap without fast rc clock");
  chk_fail_delay: assert property ($rose(oscFailTrap) |->
      monitorActive && relCnt + 24'h000001 >= MONITOR_START_CYCLES)
    else $error("fail trap before monitor delay");
  chk_hold_state: assert property ($fell(systemResetSignal) && resetCause != 3'h4 |->
      holdCnt >= 16'd2500)
    else $error("system reset hold shorter than state reset time");
  chk_mon_released: assert property ($rose(monitorActive) |->
      !systemResetSignal && $past(!systemResetSignal))
    else $error("monitor started before reset release");
endmodule // reset_release_sequencer_asserts

bind reset_release_sequencer reset_release_sequencer_asserts #(
  .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES), .MONITOR_START_CYCLES(MONITOR_START_CYCLES)
) u_chk (.clk, .rst_n, .powerOnEvent, .systemResetSignal, .clockReleased, .cpuRunEnable,
  .programCounterLoad, .currentOscSelect, .monitorActive, .oscFailTrap, .resetCause);

// >>> reset_release_sequencer_regs.vh
// Timing constants, clock source codes and reset values for the reset release sequencer.
`ifndef RESET_RELEASE_SEQUENCER_REGS_VH
`define RESET_RELEASE_SEQUENCER_REGS_VH
// ==========================================================================
// Clock and timing
`define CLK_PERIOD_NS 8
`define POWER_ON_DELAY_US 10
`define STARTUP_REG_ON_US 20
`define POWER_UP_TIMER_MS 64
`define STATE_RESET_US 20
`define PLL_LOCK_TIME_US 20
`define MONITOR_START_DELAY_US 100
`define POWER_ON_CYCLES ((`POWER_ON_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define STARTUP_REG_ON_CYCLES ((`STARTUP_REG_ON_US * 1000) / `CLK_PERIOD_NS)
`define POWER_UP_TIMER_CYCLES ((`POWER_UP_TIMER_MS * 1000000) / `CLK_PERIOD_NS)
`define STATE_RESET_CYCLES ((`STATE_RESET_US * 1000) / `CLK_PERIOD_NS)
`define PLL_LOCK_CYCLES ((`PLL_LOCK_TIME_US * 1000) / `CLK_PERIOD_NS)
`define MONITOR_START_CYCLES ((`MONITOR_START_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define OSC_STARTUP_PERIODS 1024
`define OSC_STARTUP_WIDTH 10
// ==========================================================================
// Clock source codes (3-bit oscillator selection)
`define OSC_FAST_RC 3'h0
`define OSC_FAST_RC_PLL 3'h1
`define OSC_CRYSTAL 3'h2
`define OSC_CRYSTAL_PLL 3'h3
`define OSC_SECONDARY 3'h4
`define OSC_LOW_POWER_RC 3'h5
`define OSC_EXT_CLOCK 3'h6
`define OSC_EXT_CLOCK_PLL 3'h7
// ==========================================================================
// Reset values and field positions
`define CUR_OSC_MSB 14
`define CUR_OSC_LSB 12
`define RESET_VECTOR 24'h000000
`define TIMER_WIDTH 24
`endif

// >>> tb.sv
// Self-checking testbench for the reset release sequencer.
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] ev = 9'h000;
  logic regOn = 1'b1;
  logic swEn = 1'b1;
  logic monEn = 1'b0;
  logic oscRun = 1'b0;
  logic pllOn = 1'b0;
  logic [2:0] sel = 3'h0;
  wire oscClk, pllLk, system_reset_signal, clkRel, runEn, monAct, trap;
  wire [23:0] pc;
  wire [2:0] curOsc, cause;
  int errors = 0;
  int total_checks = 0;
  int n;
  always #4 clk = ~clk;
  osc_partner_model u_osc (.clk(clk), .oscRun(oscRun), .pllOn(pllOn), .oscClockIn(oscClk),
    .pllLockedIn(pllLk));
  // Short timer and monitor counts keep the run brief.
  reset_release_sequencer #(.POWER_UP_TIMER_CYCLES(24'd50), .MONITOR_START_CYCLES(24'd40)) u_dut (
    .clk(clk), .rst_n(rst_n), .powerOnEvent(ev[0]), .brownOutEvent(ev[1]),
    .masterClearEvent(ev[2]), .watchdogEvent(ev[3]), .softwareEvent(ev[4]),
    .illegalOpEvent(ev[5]), .uninitRegEvent(ev[6]), .trapConflictEvent(ev[7]), .wakeEvent(ev[8]),
    .regulatorEnable(regOn), .clockSwitchEnable(swEn), .monitorEnable(monEn),
    .newOscSelectConfig(sel), .oscClockIn(oscClk), .pllLockedIn(pllLk),
    .systemResetSignal(system_reset_signal), .clockReleased(clkRel), .cpuRunEnable(runEn),
    .programCounterLoad(pc), .currentOscSelect(curOsc), .monitorActive(monAct),
    .oscFailTrap(trap), .resetCause(cause));
  // ==========================================================================
  // Shared tasks
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cmpSpan(string what, int lo, int hi, int got);
    total_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        errors++;
        end_sim();
      end
    end
  endtask
  task automatic fire(int idx);
    @(posedge clk) ev <= 9'h001 << idx;
    @(posedge clk) ev <= 9'h000;
    n = 0;
    tick(4);
    while (system_reset_signal !== 1'b0) tick(1);
  endtask
  task automatic waitOn(bit which);
    while ((which ? trap : clkRel) !== 1'b1) tick(1);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic s_por();
    for (int r = 0; r < 2; r++) begin
      @(posedge clk) regOn <= r[0];
      fire(0);
      cmpSpan("por hold", 3800 + r * 2450, 3806 + r * 2450, n);
      tick(3);
      cmp("por run", 24'h3, {clkRel, runEn});
      cmp("por vector", 24'h0, pc);
      cmp("por cause", 24'h1, cause);
    end
  endtask
  task automatic s_kinds();
    for (int i = 1; i < 9; i++) begin
      fire(i);
      cmpSpan("kind hold", i == 1 ? 5000 : 2500, i == 1 ? 5006 : 2506, n);
      cmp("kind cause", i == 1 ? 24'h2 : i == 8 ? 24'h4 : 24'h3, cause);
    end
    @(posedge clk) regOn <= 1'b0;
    fire(8);
    cmpSpan("wake hold", 1, 7, n);
  endtask
  task automatic s_select();
    @(posedge clk) sel <= 3'h5;
    fire(0);
    cmp("por source", 24'h5, curOsc);
    @(posedge clk) sel <= 3'h4;
    fire(2);
    cmp("master_clear_pin source", 24'h5, curOsc);
    fire(1);
    cmp("bor source", 24'h4, curOsc);
    @(posedge clk) swEn <= 1'b0;
    sel <= 3'h6;
    fire(3);
    cmp("fixed source", 24'h6, curOsc);
    @(posedge clk) swEn <= 1'b1;
  endtask
  task automatic s_ost();
    @(posedge clk) regOn <= 1'b1;
    sel <= 3'h2;
    oscRun <= 1'b1;
    fire(0);
    cmp("gated run", 24'h0, {clkRel, runEn});
    waitOn(1'b0);
    cmpSpan("ost delay", 8190, 8220, n);
    tick(1);
    cmp("ost run", 24'h1, runEn);
  endtask
  task automatic s_mon();
    @(posedge clk) regOn <= 1'b0;
    monEn <= 1'b1;
    oscRun <= 1'b0;
    sel <= 3'h7;
    fire(0);
    tick(30);
    cmp("early monitor", 24'h0, {monAct, trap});
    waitOn(1'b1);
    cmp("fail state", 24'h38, {monAct, trap, clkRel, curOsc});
    pllOn <= 1'b1;
    fire(1);
    waitOn(1'b0);
    cmpSpan("lock delay", 2550, 2562, n);
    tick(60);
    cmp("pll state", 24'h17, {monAct, trap, curOsc});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    s_por();
    s_kinds();
    s_select();
    s_ost();
    s_mon();
    end_sim();
  end
endmodule // tb
